// ===== design/nis_irq_top.sv
// Our own choice: register access over APB.
`timescale 1ns/100ps
module nis_irq_top (
	// clock and resets
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          soft_reset,
	// apb slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [nis_pkg::ADDR_W-1:0]    paddr,
	input  wire logic [nis_pkg::DATA_W-1:0]    pwdata,
	output logic      [nis_pkg::DATA_W-1:0]    prdata,
	output logic                               pready,
	output logic                               pslverr,
	// descriptor write-back reports
	input  wire nis_pkg::nis_desc_wb_type      tx_wb,
	input  wire nis_pkg::nis_desc_wb_type      rx_wb,
	// other event pulses
	input  wire nis_pkg::nis_pulse_events_type events,
	// receive engine state and dma progress
	input  wire logic                          rx_running,
	input  wire logic                          rx_pkt_start,
	input  wire logic [nis_pkg::DRAIN_W-1:0]   rx_bytes_moved,
	// host interrupt
	output logic                               host_interrupt_line
);
	import nis_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] interrupt_mask_reg_r;
	logic              global_irq_gate_r;
	logic [DATA_W-1:0] receive_config_reg_r;
	logic [DATA_W-1:0] interrupt_status_q;
	logic [DATA_W-1:0] status_view;
	logic [DATA_W-1:0] event_vec;
	logic [DATA_W-1:0] read_clr_vec;
	logic [DATA_W-1:0] prdata_r;
	logic [DATA_W-1:0] prdata_nxt;
	logic              pready_r;
	logic              pslverr_r;
	logic              host_interrupt_line_r;
	logic              host_interrupt_line_nxt;
	logic              rx_running_q;
	logic              rx_idle_pulse;
	logic              rx_early_pulse;
	logic              setup_phase;
	logic              access_done;
	nis_sel_type       setup_sel;
	nis_sel_type       access_sel;

	assign prdata              = prdata_r;
	assign pready              = pready_r;
	assign pslverr             = pslverr_r;
	assign host_interrupt_line = host_interrupt_line_r;

	// ----------------------------------------------------------------
	// apb phases
	// ----------------------------------------------------------------
	assign setup_phase = psel && !penable;
	assign access_done = psel && penable && pready_r;
	assign setup_sel   = nis_decode(paddr);
	assign access_sel  = nis_decode(paddr);

	// ready rises for exactly one access cycle after each setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
		end else begin
			pready_r <= setup_phase;
		end
	end

	// unmapped addresses answer with an error on the same ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_r <= 1'b0;
		end else begin
			pslverr_r <= setup_phase && (setup_sel == SEL_NONE);
		end
	end

	// read data is picked up in the setup cycle
	always_comb begin
		prdata_nxt = REG_RESET;
		if (setup_phase && !pwrite) begin
			case (setup_sel)
				SEL_STATUS: prdata_nxt = status_view;
				SEL_MASK:   prdata_nxt = interrupt_mask_reg_r;
				SEL_GATE:   prdata_nxt[GATE_BIT] = global_irq_gate_r;
				SEL_RECEIVE_CONFIG_REG:  prdata_nxt = receive_config_reg_r;
				default:    prdata_nxt = REG_RESET;
			endcase
		end
	end

	// read data holds through the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= REG_RESET;
		end else if (setup_phase) begin
			prdata_r <= prdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	// mask keeps only the implemented positions
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_mask_reg_r <= REG_RESET;
		end else if (soft_reset) begin
			interrupt_mask_reg_r <= REG_RESET;
		end else if (access_done && pwrite && access_sel == SEL_MASK) begin
			interrupt_mask_reg_r <= pwdata & MASK_IMPL;
		end
	end

	// global gate: one write turns the line off without read-modify-write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			global_irq_gate_r <= 1'b0;
		end else if (soft_reset) begin
			global_irq_gate_r <= 1'b0;
		end else if (access_done && pwrite && access_sel == SEL_GATE) begin
			global_irq_gate_r <= pwdata[GATE_BIT];
		end
	end

	// receive configuration holds the drain threshold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			receive_config_reg_r <= REG_RESET;
		end else if (soft_reset) begin
			receive_config_reg_r <= REG_RESET;
		end else if (access_done && pwrite && access_sel == SEL_RECEIVE_CONFIG_REG) begin
			receive_config_reg_r <= pwdata & RECEIVE_CONFIG_REG_IMPL;
		end
	end

	// ----------------------------------------------------------------
	// event sources
	// ----------------------------------------------------------------
	// running to idle transition of the receive engine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_running_q <= 1'b0;
		end else begin
			rx_running_q <= rx_running;
		end
	end
	assign rx_idle_pulse = rx_running_q && !rx_running;

	nis_rx_early u_rx_early (
		.clk         (pclk),
		.rst_n       (presetn),
		.soft_clr    (soft_reset),
		.pkt_start   (rx_pkt_start),
		.bytes_moved (rx_bytes_moved),
		.threshold   (receive_config_reg_r[DRAIN_W-1:0]),
		.early_pulse (rx_early_pulse)
	);

	// gather the set vector; the mask plays no part here
	always_comb begin
		event_vec                   = REG_RESET;
		event_vec[BIT_TX_DESC]      = tx_wb.writeback && tx_wb.host_interrupt_line_req;
		event_vec[BIT_TX_GOOD]      = tx_wb.writeback && tx_wb.last && tx_wb.ok;
		event_vec[BIT_TX_FAILED]    = tx_wb.writeback && tx_wb.last && !tx_wb.ok;
		event_vec[BIT_RX_OVERFLOW]  = events.rx_fifo_overflow;
		event_vec[BIT_RX_IDLE]      = rx_idle_pulse;
		event_vec[BIT_RX_EARLY]     = rx_early_pulse;
		event_vec[BIT_RX_FAILED]    = rx_wb.writeback && rx_wb.last && !rx_wb.ok;
		event_vec[BIT_RX_DESC]      = rx_wb.writeback && rx_wb.host_interrupt_line_req;
		event_vec[BIT_RX_GOOD]      = rx_wb.writeback && rx_wb.last && rx_wb.ok;
		event_vec[BIT_TX_IDLE]      = events.tx_engine_idle;
		event_vec[BIT_TX_UNDERFLOW] = events.tx_fifo_underflow;
		event_vec[BIT_STATS]        = events.statistics_service;
		event_vec[BIT_SOFTWARE]     = events.software;
		event_vec[BIT_WAKE]         = events.wake;
		event_vec[BIT_PHY]          = events.phy;
		event_vec[BIT_RX_STS_OVF]   = events.rx_status_fifo_overflow;
		event_vec[BIT_TARGET_ABORT] = events.target_abort;
		event_vec[BIT_MASTER_ABORT] = events.master_abort;
		event_vec[BIT_SYSTEM_ERROR] = events.system_error;
		event_vec[BIT_PARITY_ERROR] = events.parity_error;
		event_vec[BIT_RX_RST_DONE]  = events.rx_reset_done;
		event_vec[BIT_TX_RST_DONE]  = events.tx_reset_done;
	end

	// ----------------------------------------------------------------
	// status register
	// ----------------------------------------------------------------
	// clear only what the read returned, so a bit set after the setup cycle survives
	assign read_clr_vec = (access_done && !pwrite && access_sel == SEL_STATUS) ?
		prdata_r : REG_RESET;

	nis_sticky_bits u_status (
		.clk      (pclk),
		.rst_n    (presetn),
		.soft_clr (soft_reset),
		.set_vec  (event_vec),
		.clr_vec  (read_clr_vec),
		.bits_q   (interrupt_status_q)
	);

	// summary bit follows the high group live
	always_comb begin
		status_view                   = interrupt_status_q;
		status_view[BIT_HIGH_SUMMARY] = |(interrupt_status_q & HIGH_GROUP);
	end

	// ----------------------------------------------------------------
	// interrupt output
	// ----------------------------------------------------------------
	assign host_interrupt_line_nxt = global_irq_gate_r &&
		|(status_view & interrupt_mask_reg_r);

	// registered so the line never glitches on the host side
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_interrupt_line_r <= 1'b0;
		end else begin
			host_interrupt_line_r <= host_interrupt_line_nxt;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [1:0] early_in_pkt;

	// counts early events inside one packet
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			early_in_pkt <= 2'h0;
		end else if (rx_pkt_start || soft_reset) begin
			early_in_pkt <= 2'h0;
		end else if (rx_early_pulse && early_in_pkt != 2'h3) begin
			early_in_pkt <= early_in_pkt + 2'h1;
		end
	end

	chk_tx_desc_set: assert property (
		@(posedge pclk) disable iff (!presetn)
		(tx_wb.writeback && tx_wb.host_interrupt_line_req && !soft_reset) |=> interrupt_status_q[BIT_TX_DESC]
	) else $error("tx descriptor event did not set its status bit");

	chk_tx_good_set: assert property (
		@(posedge pclk) disable iff (!presetn)
		(tx_wb.writeback && tx_wb.last && tx_wb.ok && !soft_reset)
			|=> interrupt_status_q[BIT_TX_GOOD]
	) else $error("tx good event did not set its status bit");

	chk_rx_overflow_set: assert property (
		@(posedge pclk) disable iff (!presetn)
		(events.rx_fifo_overflow && !soft_reset) |=> interrupt_status_q[BIT_RX_OVERFLOW]
	) else $error("rx overflow did not set its status bit");

	chk_rx_idle_set: assert property (
		@(posedge pclk) disable iff (!presetn)
		(rx_running ##1 (!rx_running && !soft_reset)) |=> interrupt_status_q[BIT_RX_IDLE]
	) else $error("rx idle transition did not set its status bit");

	chk_early_once: assert property (
		@(posedge pclk) disable iff (!presetn)
		early_in_pkt <= 2'h1
	) else $error("early threshold event fired twice in one packet");

	chk_rx_failed_set: assert property (
		@(posedge pclk) disable iff (!presetn)
		(rx_wb.writeback && rx_wb.last && !rx_wb.ok && !soft_reset)
			|=> interrupt_status_q[BIT_RX_FAILED] && !$past(event_vec[BIT_RX_GOOD])
	) else $error("rx failed event did not set its status bit");

	chk_rx_desc_set: assert property (
		@(posedge pclk) disable iff (!presetn)
		(rx_wb.writeback && rx_wb.host_interrupt_line_req && !soft_reset) |=> interrupt_status_q[BIT_RX_DESC]
	) else $error("rx descriptor event did not set its status bit");

	chk_rx_good_set: assert property (
		@(posedge pclk) disable iff (!presetn)
		(rx_wb.writeback && rx_wb.last && rx_wb.ok && !soft_reset)
			|=> interrupt_status_q[BIT_RX_GOOD]
	) else $error("rx good event did not set its status bit");

	chk_mask_gates_line: assert property (
		@(posedge pclk) disable iff (!presetn)
		(global_irq_gate_r && (status_view & interrupt_mask_reg_r) != REG_RESET)
			|=> host_interrupt_line_r
	) else $error("unmasked status bit did not raise the interrupt");

	chk_mask_unused_zero: assert property (
		@(posedge pclk) disable iff (!presetn)
		(interrupt_mask_reg_r & ~MASK_IMPL) == REG_RESET
	) else $error("unused mask bit is set");

	chk_status_ignores_mask: assert property (
		@(posedge pclk) disable iff (!presetn)
		(event_vec != REG_RESET && interrupt_mask_reg_r == REG_RESET && !soft_reset)
			|=> (interrupt_status_q & $past(event_vec)) == $past(event_vec)
	) else $error("masked event was not latched");

	chk_mask_soft_clear: assert property (
		@(posedge pclk) disable iff (!presetn)
		soft_reset |=> interrupt_mask_reg_r == REG_RESET && !global_irq_gate_r
	) else $error("soft reset did not clear the mask");

	chk_read_clears: assert property (
		@(posedge pclk) disable iff (!presetn)
		(access_done && !pwrite && access_sel == SEL_STATUS && event_vec == REG_RESET)
			|=> (interrupt_status_q & $past(prdata_r)) == REG_RESET
	) else $error("status read did not clear the returned bits");

	chk_high_summary: assert property (
		@(posedge pclk) disable iff (!presetn)
		(setup_phase && !pwrite && setup_sel == SEL_STATUS)
			|=> prdata_r[BIT_HIGH_SUMMARY] == $past(|(interrupt_status_q & HIGH_GROUP))
	) else $error("summary bit does not match the high group");

	chk_gate_off_quiet: assert property (
		@(posedge pclk) disable iff (!presetn)
		!global_irq_gate_r |=> !host_interrupt_line_r
	) else $error("interrupt raised while the global gate is off");

	chk_line_released: assert property (
		@(posedge pclk) disable iff (!presetn)
		((status_view & interrupt_mask_reg_r) == REG_RESET) |=> !host_interrupt_line_r
	) else $error("interrupt held with no unmasked status bit");

	// first edge out of hard reset: nothing may interrupt before software opens the mask
	chk_mask_hard_reset: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> interrupt_mask_reg_r == REG_RESET && !host_interrupt_line_r
	) else $error("mask or line not clear after hard reset");

	chk_gate_keeps_mask: assert property (
		@(posedge pclk) disable iff (!presetn)
		(access_done && pwrite && access_sel == SEL_GATE && !soft_reset)
			|=> $stable(interrupt_mask_reg_r)
	) else $error("gate write altered the mask");

endmodule

// ===== design/nis_rx_early.sv
`timescale 1ns/100ps
module nis_rx_early (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	input  wire logic                        soft_clr,
	// receive dma progress
	input  wire logic                        pkt_start,
	input  wire logic [nis_pkg::DRAIN_W-1:0] bytes_moved,
	input  wire logic [nis_pkg::DRAIN_W-1:0] threshold,
	// one-cycle event
	output logic                             early_pulse
);
	import nis_pkg::*;

	logic armed_r;
	logic hit;

	// a zero threshold disables the event rather than firing on every packet start
	assign hit = armed_r && !pkt_start && (threshold != '0) && (bytes_moved >= threshold);

	// ----------------------------------------------------------------
	// arm on packet start, disarm after the one event
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			armed_r <= 1'b0;
		end else if (soft_clr) begin
			armed_r <= 1'b0;
		end else if (pkt_start) begin
			armed_r <= 1'b1;
		end else if (hit) begin
			armed_r <= 1'b0;
		end
	end

	// registered pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			early_pulse <= 1'b0;
		end else begin
			early_pulse <= hit && !soft_clr;
		end
	end

endmodule

// ===== design/nis_sticky_bits.sv
`timescale 1ns/100ps
module nis_sticky_bits (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       soft_clr,
	// set and clear vectors
	input  wire logic [nis_pkg::DATA_W-1:0] set_vec,
	input  wire logic [nis_pkg::DATA_W-1:0] clr_vec,
	// latched bits
	output logic      [nis_pkg::DATA_W-1:0] bits_q
);
	import nis_pkg::*;

	// ----------------------------------------------------------------
	// one flag per implemented position
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < DATA_W; i++) begin : g_bit
			if (STICKY_IMPL[i]) begin : g_impl
				// set beats clear so an event landing on the read is kept
				always_ff @(posedge clk or negedge rst_n) begin
					if (!rst_n) begin
						bits_q[i] <= 1'b0;
					end else if (soft_clr) begin
						bits_q[i] <= 1'b0;
					end else begin
						bits_q[i] <= set_vec[i] | (bits_q[i] & ~clr_vec[i]);
					end
				end
			end else begin : g_none
				assign bits_q[i] = 1'b0; // unused and summary positions hold nothing
			end
		end
	endgenerate

endmodule

// ===== shared/nis_pkg.sv
// Notes on behaviour
// - a transmit descriptor written back with its interrupt request flag set sets status bit 7.
// - the last transmit descriptor of a good transmission, written back with status, sets bit 6.
// - every receive data FIFO overflow sets status bit 5.
// - the receive engine going from running to idle sets status bit 4.
// - status bit 3 is set at most once per packet, when receive DMA has moved the threshold bytes.
// - the last receive descriptor of a failed reception, written back with status, sets bit 2.
// - a receive descriptor written back with its interrupt request flag set sets status bit 1.
// - the last receive descriptor of a good packet, written back with status, sets bit 0.
// - a mask bit of one lets its status bit raise the interrupt, a zero blocks it.
// - mask bits exist at 25 to 20 and 16 to 0; bits 31 to 26 and 19 to 17 read zero.
// - status bits are set by their events whatever the mask holds.
// - hard reset clears the whole mask so nothing interrupts until software enables it.
// - the mask is a 32-bit read-write register at 0x14, cleared by hard and soft reset.
// - reading the status register clears its status bits.
// - status bit 15 is the OR of status bits 25 to 16.
// - the global gate bit blocks the interrupt output without touching status or mask.
package nis_pkg;

	// ----------------------------------------------------------------
	// bus and register map
	// ----------------------------------------------------------------
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_GATE   = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_RECEIVE_CONFIG_REG  = 8'h34;

	// ----------------------------------------------------------------
	// field layout and reset values
	// ----------------------------------------------------------------
	localparam logic [DATA_W-1:0] MASK_IMPL   = 32'h03f1ffff; // implemented mask bits
	localparam logic [DATA_W-1:0] STICKY_IMPL = 32'h03f17fff; // latched status bits
	localparam logic [DATA_W-1:0] HIGH_GROUP  = 32'h03f10000; // summarised into bit 15
	localparam logic [DATA_W-1:0] REG_RESET   = 32'h00000000;
	localparam int unsigned BIT_RX_GOOD      = 0;
	localparam int unsigned BIT_RX_DESC      = 1;
	localparam int unsigned BIT_RX_FAILED    = 2;
	localparam int unsigned BIT_RX_EARLY     = 3;
	localparam int unsigned BIT_RX_IDLE      = 4;
	localparam int unsigned BIT_RX_OVERFLOW  = 5;
	localparam int unsigned BIT_TX_GOOD      = 6;
	localparam int unsigned BIT_TX_DESC      = 7;
	localparam int unsigned BIT_TX_FAILED    = 8;
	localparam int unsigned BIT_TX_IDLE      = 9;
	localparam int unsigned BIT_TX_UNDERFLOW = 10;
	localparam int unsigned BIT_STATS        = 11;
	localparam int unsigned BIT_SOFTWARE     = 12;
	localparam int unsigned BIT_WAKE         = 13;
	localparam int unsigned BIT_PHY          = 14;
	localparam int unsigned BIT_HIGH_SUMMARY = 15;
	localparam int unsigned BIT_RX_STS_OVF   = 16;
	localparam int unsigned BIT_TARGET_ABORT = 20;
	localparam int unsigned BIT_MASTER_ABORT = 21;
	localparam int unsigned BIT_SYSTEM_ERROR = 22;
	localparam int unsigned BIT_PARITY_ERROR = 23;
	localparam int unsigned BIT_RX_RST_DONE  = 24;
	localparam int unsigned BIT_TX_RST_DONE  = 25;
	localparam int unsigned GATE_BIT         = 0;
	localparam int unsigned DRAIN_W          = 12;
	localparam logic [DATA_W-1:0] RECEIVE_CONFIG_REG_IMPL = 32'h00000fff; // drain threshold in bytes

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic writeback; // one-cycle pulse: descriptor written back with valid status
		logic host_interrupt_line_req;  // descriptor-level interrupt request flag
		logic last;      // last descriptor of the packet
		logic ok;        // packet completed without error
	} nis_desc_wb_type;

	typedef struct packed {
		logic tx_reset_done;
		logic rx_reset_done;
		logic parity_error;
		logic system_error;
		logic master_abort;
		logic target_abort;
		logic rx_status_fifo_overflow;
		logic phy;
		logic wake;
		logic software;
		logic statistics_service;
		logic tx_fifo_underflow;
		logic tx_engine_idle;
		logic tx_failed;
		logic rx_fifo_overflow;
	} nis_pulse_events_type;

	typedef enum logic [2:0] {SEL_NONE, SEL_STATUS, SEL_MASK, SEL_GATE, SEL_RECEIVE_CONFIG_REG} nis_sel_type;

	// address decode shared by the setup and access phases
	function automatic nis_sel_type nis_decode(input logic [ADDR_W-1:0] addr);
		case (addr)
			OFS_STATUS: nis_decode = SEL_STATUS;
			OFS_MASK:   nis_decode = SEL_MASK;
			OFS_GATE:   nis_decode = SEL_GATE;
			OFS_RECEIVE_CONFIG_REG:  nis_decode = SEL_RECEIVE_CONFIG_REG;
			default:    nis_decode = SEL_NONE;
		endcase
	endfunction

endpackage

// ===== verif/nic_interrupt_status_mask_tb_top.sv
`timescale 1ns/100ps
module nic_interrupt_status_mask_tb_top;
	import nis_pkg::*;
	// ----------------------------------------------------------------
	// stimulus, responses and the reference state
	// ----------------------------------------------------------------
	logic                 pclk = 1'b0;
	logic                 presetn, soft_reset, psel, penable, pwrite;
	logic                 pready, pslverr, irq, rx_running, rx_pkt_start, er;
	logic [ADDR_W-1:0]    paddr;
	logic [DATA_W-1:0]    pwdata, prdata, rd;
	logic [DRAIN_W-1:0]   rx_bytes_moved;
	nis_desc_wb_type      tx_wb, rx_wb;
	nis_pulse_events_type events;
	int                   error_cnt = 0, n_compared = 0, cycles = 0, taken;
	int unsigned          seed = 26268, exp_st = 0, exp_mask;
	int                   ev_list[9] = '{0, 1, 2, 3, 4, 5, 6, 7, 20};

	// 200 MHz clock
	always #2.5 pclk = ~pclk;

	nis_irq_top uut (.pclk(pclk), .presetn(presetn), .soft_reset(soft_reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tx_wb(tx_wb), .rx_wb(rx_wb), .events(events),
		.rx_running(rx_running), .rx_pkt_start(rx_pkt_start), .rx_bytes_moved(rx_bytes_moved),
		.host_interrupt_line(irq));
	nis_host_model host (.pclk(pclk), .irq(irq), .taken_cnt(taken));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic int unsigned xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic conclude();
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("MISMATCH %s exp %h got %h", n, e, g);
			error_cnt++;
		end
	endtask

	// one apb transfer; the leading edge keeps strobes from being driven twice in a step
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// raise the source of status bit i for one cycle, then let it land
	task automatic fire(input int i);
		@(posedge pclk);
		case (i)
			0: rx_wb <= 4'b1011;
			1: rx_wb <= 4'b1100;
			2: rx_wb <= 4'b1010;
			3: rx_pkt_start <= 1'b1;
			4: rx_running <= 1'b0;
			5: events.rx_fifo_overflow <= 1'b1;
			6: tx_wb <= 4'b1011;
			7: tx_wb <= 4'b1100;
			default: events.target_abort <= 1'b1;
		endcase
		@(posedge pclk);
		{rx_wb, tx_wb, events, rx_pkt_start, rx_running} <= {24'h0, 1'b1};
		rx_bytes_moved <= (i == 3) ? 12'h014 : 12'h000;
		repeat (5) @(posedge pclk);
		exp_st |= (1 << i) | ((i == 20) ? 32'h8000 : 0);
	endtask

	// a hang counts as a mismatch and ends the run
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			conclude();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{presetn, soft_reset, psel, penable, pwrite, paddr, pwdata} = '0;
		{tx_wb, rx_wb, events, rx_pkt_start, rx_bytes_moved} = '0;
		rx_running = 1'b1;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, OFS_MASK, 0);
		chk("mask_reset", 0, rd);
		chk("irq_reset", 0, {31'h0, irq});
		repeat (4) begin
			exp_mask = xs();
			apb(1, OFS_MASK, exp_mask);
			apb(0, OFS_MASK, 0);
			chk("mask_rw", exp_mask & 32'h03f1ffff, rd);
		end
		apb(0, 8'h3c, 0);
		chk("unmapped_err", 1, {31'h0, er});
		chk("unmapped_data", 0, rd);
		apb(1, OFS_MASK, 0);
		apb(1, OFS_RECEIVE_CONFIG_REG, 32'h10);
		apb(1, OFS_GATE, 1);
		// each event in ev_list latches with its mask clear, and a read clears it
		foreach (ev_list[k]) begin
			fire(ev_list[k]);
			chk("irq_masked", 0, {31'h0, irq});
			apb(0, OFS_STATUS, 0);
			chk("status", exp_st, rd);
			exp_st = 0;
			apb(0, OFS_STATUS, 0);
			chk("status_cleared", 0, rd);
		end
		// unmasked events drive the line, and the gate blocks it
		foreach (ev_list[k]) begin
			apb(1, OFS_MASK, 1 << ev_list[k]);
			fire(ev_list[k]);
			chk("irq_on", 1, {31'h0, irq});
			apb(1, OFS_GATE, 0);
			repeat (2) @(posedge pclk);
			chk("irq_gated", 0, {31'h0, irq});
			apb(1, OFS_GATE, 1);
			repeat (2) @(posedge pclk);
			chk("irq_regate", 1, {31'h0, irq});
			apb(0, OFS_STATUS, 0);
			chk("status_kept", exp_st, rd);
			exp_st = 0;
			repeat (2) @(posedge pclk);
			chk("irq_off", 0, {31'h0, irq});
		end
		chk("host_takes", 18, taken);
		apb(1, OFS_MASK, 32'hffffffff);
		@(posedge pclk);
		soft_reset <= 1'b1;
		@(posedge pclk);
		soft_reset <= 1'b0;
		apb(0, OFS_MASK, 0);
		chk("mask_soft", 0, rd);
		conclude();
	end
endmodule

// ===== verif/nis_host_model.sv
`timescale 1ns/100ps
module nis_host_model (
	// clock
	input  wire logic pclk,
	// level interrupt from the device
	input  wire logic irq,
	// interrupts taken by the host
	output int        taken_cnt
);
	logic irq_r;
	// a level line: only a rising edge is a new request to service
	initial begin
		taken_cnt = 0;
		irq_r = 1'b0;
	end
	always @(posedge pclk) begin
		if (irq === 1'b1 && irq_r !== 1'b1) begin
			taken_cnt++;
		end
		irq_r <= irq;
	end
endmodule
